// ===== design/acmp_input_route.sv
// input channel decode for one comparator: one connect strobe per analog source
module acmp_input_route (
  input  wire logic       enable_in,
  input  wire logic [2:0] pos_sel_in,
  input  wire logic [2:0] neg_sel_in,
  output logic      [3:0] pos_conn_out,
  output logic      [5:0] neg_conn_out
);
  // pos: 0 pin, 1 dac, 2 reference, 3 ground; neg: 0-3 pins, 4 reference, 5 ground
  always_comb begin
    pos_conn_out = 4'h0;
    neg_conn_out = 6'h00;
    if (enable_in) begin
      unique case (pos_sel_in)
        3'h0:    pos_conn_out = 4'h1;
        3'h5:    pos_conn_out = 4'h2;
        3'h6:    pos_conn_out = 4'h4;
        3'h7:    pos_conn_out = 4'h8;
        default: pos_conn_out = 4'h0;
      endcase
      unique case (neg_sel_in)
        3'h0:    neg_conn_out = 6'h01;
        3'h1:    neg_conn_out = 6'h02;
        3'h2:    neg_conn_out = 6'h04;
        3'h3:    neg_conn_out = 6'h08;
        3'h6:    neg_conn_out = 6'h10;
        3'h7:    neg_conn_out = 6'h20;
        default: neg_conn_out = 6'h00;
      endcase
    end
  end
endmodule

// ===== design/acmp_sync2.sv
// two flip-flop synchroniser for levels entering from outside the clock domain
module acmp_sync2 #(
  parameter int W = 11
) (
  input  wire logic         clk_in,
  input  wire logic         rst_in,
  input  wire logic [W-1:0] d_in,
  output logic      [W-1:0] q_out
);
  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] safe;
  } sync_state_t;

  sync_state_t st_r;
  sync_state_t st_nxt;

  // meta is read only by the second stage
  always_comb begin
    st_nxt      = st_r;
    st_nxt.meta = d_in;
    st_nxt.safe = st_r.meta;
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign q_out = st_r.safe;
endmodule

// ===== design/analog_comparator_digital_ctrl.sv
// digital control, status and event logic of the two analog comparators
//
// The AXI4-Lite slave port and the register addresses were chosen for this implementation.
`include "acmp_defines.svh"
module analog_comparator_digital_ctrl (
  input  wire logic        SYS_CLK_IN,
  input  wire logic        RST_IN,
  input  wire logic [7:0]  S_AXI_AWADDR_IN,
  input  wire logic        S_AXI_AWVALID_IN,
  output logic             S_AXI_AWREADY_OUT,
  input  wire logic [31:0] S_AXI_WDATA_IN,
  input  wire logic [3:0]  S_AXI_WSTRB_IN,
  input  wire logic        S_AXI_WVALID_IN,
  output logic             S_AXI_WREADY_OUT,
  output logic [1:0]       S_AXI_BRESP_OUT,
  output logic             S_AXI_BVALID_OUT,
  input  wire logic        S_AXI_BREADY_IN,
  input  wire logic [7:0]  S_AXI_ARADDR_IN,
  input  wire logic        S_AXI_ARVALID_IN,
  output logic             S_AXI_ARREADY_OUT,
  output logic [31:0]      S_AXI_RDATA_OUT,
  output logic [1:0]       S_AXI_RRESP_OUT,
  output logic             S_AXI_RVALID_OUT,
  input  wire logic        S_AXI_RREADY_IN,
  input  wire logic [1:0]  CMP_RAW_IN,
  input  wire logic        T1_CLK_IN,
  input  wire logic [7:0]  PORT_PIN_IN,
  output logic [1:0]       CMP_ENABLE_OUT,
  output logic [1:0]       CMP_SPEED_OUT,
  output logic [1:0]       CMP_HYSTERESIS_EN_OUT,
  output logic [7:0]       POS_CONNECT_OUT,
  output logic [11:0]      NEG_CONNECT_OUT,
  output logic [1:0]       CMP_PIN_OUT,
  output logic [1:0]       TMR1_GATE_OUT,
  output logic [1:0]       SHUTDOWN_REQ_OUT,
  output logic [1:0]       CMP_IRQ_FLAG_OUT,
  output logic [1:0]       CMP_IRQ_REQ_OUT
);
  acmp_pkg::core_state_t st_r;
  acmp_pkg::core_state_t st_nxt;

  logic [10:0] sync_q;
  logic [1:0]  raw_s;
  logic [7:0]  pins_s;
  logic        t1_s;
  logic        icyc;
  logic        t1_fall;
  logic [1:0]  gated;
  logic [1:0]  rise;
  logic [1:0]  fall;
  logic [1:0]  set_ev;
  logic [1:0]  clr_ev;
  logic        aw_hs;
  logic        w_hs;
  logic        ar_hs;
  logic        wr_do;

  // pins, the timer clock and the analog decisions are all asynchronous here
  acmp_sync2 #(
    .W(11)
  ) u_sync (
    .clk_in (SYS_CLK_IN),
    .rst_in (RST_IN),
    .d_in   ({T1_CLK_IN, PORT_PIN_IN, CMP_RAW_IN}),
    .q_out  (sync_q)
  );

  assign raw_s  = sync_q[1:0];
  assign pins_s = sync_q[9:2];
  assign t1_s   = sync_q[10];

  // instruction cycle is every fourth system clock
  assign icyc    = (st_r.div == `ACMP_INSTR_DIV);
  assign t1_fall = st_r.t1_prev & ~t1_s;

  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++) begin : g_cmp
      assign gated[gi] = (st_r.en[gi] & raw_s[gi]) ^ st_r.inv[gi];
      assign rise[gi]   = icyc & st_r.res[gi] & ~st_r.prev[gi];
      assign fall[gi]   = icyc & ~st_r.res[gi] & st_r.prev[gi];
      assign set_ev[gi] = (rise[gi] & st_r.rise_en[gi]) | (fall[gi] & st_r.fall_en[gi]);
      acmp_input_route u_route (
        .enable_in    (st_r.en[gi]),
        .pos_sel_in   (st_r.psel[gi]),
        .neg_sel_in   (st_r.nsel[gi]),
        .pos_conn_out (POS_CONNECT_OUT[gi*4 +: 4]),
        .neg_conn_out (NEG_CONNECT_OUT[gi*6 +: 6])
      );
    end
  endgenerate

  assign aw_hs = S_AXI_AWVALID_IN & S_AXI_AWREADY_OUT;
  assign w_hs  = S_AXI_WVALID_IN & S_AXI_WREADY_OUT;
  assign ar_hs = S_AXI_ARVALID_IN & S_AXI_ARREADY_OUT;
  assign wr_do = (st_r.wst == acmp_pkg::WR_EXEC);

  // only a write of zero clears a flag
  assign clr_ev = (wr_do && st_r.wlane && st_r.awaddr == `ACMP_REG_IRQ_FLAG) ?
                  ~st_r.wbyte[1:0] : 2'b00;

  function automatic logic [7:0] ctrl0_byte(input acmp_pkg::core_state_t s, input int i);
    ctrl0_byte = 8'h00;
    ctrl0_byte[`ACMP_C0_ENABLE] = s.en[i];
    ctrl0_byte[`ACMP_C0_RESULT] = s.res[i];
    ctrl0_byte[`ACMP_C0_INVERT] = s.inv[i];
    ctrl0_byte[`ACMP_C0_SPEED]  = s.spd[i];
    ctrl0_byte[`ACMP_C0_HYS]    = s.hys[i];
    ctrl0_byte[`ACMP_C0_SYNC]   = s.sync[i];
  endfunction

  function automatic logic [7:0] ctrl1_byte(input acmp_pkg::core_state_t s, input int i);
    ctrl1_byte = {s.rise_en[i], s.fall_en[i], s.psel[i], s.nsel[i]};
  endfunction

  function automatic logic [8:0] read_byte(input acmp_pkg::core_state_t s,
                                           input logic [7:0] a,
                                           input logic [7:0] pins);
    // bit 8 flags an unmapped address
    read_byte = 9'h000;
    unique case (a)
      `ACMP_REG_CTRL0_C1: read_byte[7:0] = ctrl0_byte(s, 0);
      `ACMP_REG_CTRL1_C1: read_byte[7:0] = ctrl1_byte(s, 0);
      `ACMP_REG_CTRL0_C2: read_byte[7:0] = ctrl0_byte(s, 1);
      `ACMP_REG_CTRL1_C2: read_byte[7:0] = ctrl1_byte(s, 1);
      `ACMP_REG_MIRROR:   read_byte[7:0] = {6'h00, s.res};
      `ACMP_REG_IRQ_FLAG: read_byte[7:0] = {6'h00, s.flag};
      `ACMP_REG_IRQ_EN:   read_byte[7:0] = {6'h00, s.irq_en};
      `ACMP_REG_SHUTDOWN: read_byte[7:0] = {6'h00, s.ase};
      `ACMP_REG_ANALOG_SELECT:    read_byte[7:0] = s.analog_select;
      `ACMP_REG_PORT:     read_byte[7:0] = pins & ~s.analog_select;
      default:            read_byte      = 9'h100;
    endcase
  endfunction

  always_comb begin
    logic [8:0] rb;
    logic       mapped;
    rb     = read_byte(st_r, S_AXI_ARADDR_IN, pins_s);
    mapped = 1'b0;
    st_nxt = st_r;
    st_nxt.div     = st_r.div + 2'h1;
    st_nxt.t1_prev = t1_s;
    for (int i = 0; i < 2; i++) begin
      if (icyc) begin
        st_nxt.res[i]  = gated[i];
        st_nxt.prev[i] = st_r.res[i];
      end
      // falling timer edge when synced, else follow
      if (!st_r.sync[i] || t1_fall) begin
        st_nxt.pin[i] = gated[i];
      end
      st_nxt.flag[i] = (st_r.flag[i] & ~clr_ev[i]) | set_ev[i];
    end
    // write channels, address and data in either order
    if (aw_hs) begin
      st_nxt.aw_have = 1'b1;
      st_nxt.awaddr  = S_AXI_AWADDR_IN;
    end
    if (w_hs) begin
      st_nxt.w_have = 1'b1;
      st_nxt.wbyte  = S_AXI_WDATA_IN[7:0];
      st_nxt.wlane  = S_AXI_WSTRB_IN[0];
    end
    unique case (st_r.wst)
      acmp_pkg::WR_COLLECT: begin
        if (st_r.aw_have && st_r.w_have) begin
          st_nxt.wst = acmp_pkg::WR_EXEC;
        end
      end
      acmp_pkg::WR_EXEC: begin
        for (int i = 0; i < 2; i++) begin
          if (st_r.awaddr == (i == 0 ? `ACMP_REG_CTRL0_C1 : `ACMP_REG_CTRL0_C2)) begin
            mapped = 1'b1;
            if (st_r.wlane) begin
              st_nxt.en[i]   = st_r.wbyte[`ACMP_C0_ENABLE];
              st_nxt.inv[i]  = st_r.wbyte[`ACMP_C0_INVERT];
              st_nxt.spd[i]  = st_r.wbyte[`ACMP_C0_SPEED];
              st_nxt.hys[i]  = st_r.wbyte[`ACMP_C0_HYS];
              st_nxt.sync[i] = st_r.wbyte[`ACMP_C0_SYNC];
            end
          end
          if (st_r.awaddr == (i == 0 ? `ACMP_REG_CTRL1_C1 : `ACMP_REG_CTRL1_C2)) begin
            mapped = 1'b1;
            if (st_r.wlane) begin
              st_nxt.rise_en[i] = st_r.wbyte[`ACMP_C1_RISE];
              st_nxt.fall_en[i] = st_r.wbyte[`ACMP_C1_FALL];
              st_nxt.psel[i]    = st_r.wbyte[`ACMP_C1_POS_LSB +: 3];
              st_nxt.nsel[i]    = st_r.wbyte[`ACMP_C1_NEG_LSB +: 3];
            end
          end
        end
        if (st_r.wlane) begin
          if (st_r.awaddr == `ACMP_REG_IRQ_EN) begin
            st_nxt.irq_en = st_r.wbyte[1:0];
          end
          if (st_r.awaddr == `ACMP_REG_SHUTDOWN) begin
            st_nxt.ase = st_r.wbyte[1:0];
          end
          if (st_r.awaddr == `ACMP_REG_ANALOG_SELECT) begin
            st_nxt.analog_select = st_r.wbyte;
          end
        end
        // read-only registers accept the write and ignore it
        mapped = mapped || (st_r.awaddr == `ACMP_REG_IRQ_EN) ||
                 (st_r.awaddr == `ACMP_REG_SHUTDOWN) || (st_r.awaddr == `ACMP_REG_ANALOG_SELECT) ||
                 (st_r.awaddr == `ACMP_REG_IRQ_FLAG) || (st_r.awaddr == `ACMP_REG_MIRROR) ||
                 (st_r.awaddr == `ACMP_REG_PORT);
        st_nxt.bresp   = mapped ? `ACMP_RESP_OKAY : `ACMP_RESP_SLVERR;
        st_nxt.bvalid  = 1'b1;
        st_nxt.aw_have = 1'b0;
        st_nxt.w_have  = 1'b0;
        st_nxt.wst     = acmp_pkg::WR_RESP;
      end
      acmp_pkg::WR_RESP: begin
        if (S_AXI_BREADY_IN) begin
          st_nxt.bvalid = 1'b0;
          st_nxt.wst    = acmp_pkg::WR_COLLECT;
        end
      end
    endcase
    // read answers one cycle after the address is taken
    if (st_r.rvalid && S_AXI_RREADY_IN) begin
      st_nxt.rvalid = 1'b0;
    end
    if (ar_hs) begin
      st_nxt.rvalid = 1'b1;
      st_nxt.rdata  = {24'h000000, rb[7:0]};
      st_nxt.rresp  = rb[8] ? `ACMP_RESP_SLVERR : `ACMP_RESP_OKAY;
    end
  end

  always_ff @(posedge SYS_CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      st_r       <= '0;
      st_r.spd   <= 2'h3;
      st_r.wst   <= acmp_pkg::WR_COLLECT;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign S_AXI_AWREADY_OUT = (st_r.wst == acmp_pkg::WR_COLLECT) & ~st_r.aw_have;
  assign S_AXI_WREADY_OUT  = (st_r.wst == acmp_pkg::WR_COLLECT) & ~st_r.w_have;
  assign S_AXI_BVALID_OUT  = st_r.bvalid;
  assign S_AXI_BRESP_OUT   = st_r.bresp;
  assign S_AXI_ARREADY_OUT = ~st_r.rvalid;
  assign S_AXI_RVALID_OUT  = st_r.rvalid;
  assign S_AXI_RDATA_OUT   = st_r.rdata;
  assign S_AXI_RRESP_OUT   = st_r.rresp;

  assign CMP_ENABLE_OUT        = st_r.en;
  assign CMP_SPEED_OUT         = st_r.spd;
  assign CMP_HYSTERESIS_EN_OUT = st_r.hys & st_r.en;
  assign CMP_PIN_OUT           = st_r.pin;
  assign TMR1_GATE_OUT         = st_r.pin;
  assign SHUTDOWN_REQ_OUT      = st_r.pin & st_r.ase;
  assign CMP_IRQ_FLAG_OUT      = st_r.flag;
  // the interrupt controller applies the master and global enables
  assign CMP_IRQ_REQ_OUT       = st_r.flag & st_r.irq_en;

  default clocking cb @(posedge SYS_CLK_IN); endclocking
  default disable iff (RST_IN);

  AST_DISABLED_OPEN: assert property (
    !st_r.en[0] |-> POS_CONNECT_OUT[3:0] == 4'h0 && NEG_CONNECT_OUT[5:0] == 6'h00)
    else $error("disabled comparator has a connected input");
  AST_DISABLED_OPEN_C2: assert property (
    !st_r.en[1] |-> POS_CONNECT_OUT[7:4] == 4'h0 && NEG_CONNECT_OUT[11:6] == 6'h00)
    else $error("disabled second comparator has a connected input");
  AST_POS_OPEN_CODES: assert property (
    st_r.psel[0] != 3'h0 && st_r.psel[0] < 3'h5 |-> POS_CONNECT_OUT[3:0] == 4'h0)
    else $error("unused positive code connected a source");
  AST_NEG_OPEN_CODES: assert property (
    st_r.nsel[0] == 3'h4 || st_r.nsel[0] == 3'h5 |-> NEG_CONNECT_OUT[5:0] == 6'h00)
    else $error("unused negative code connected a source");
  AST_MIRROR_READ: assert property (
    ar_hs && S_AXI_ARADDR_IN == `ACMP_REG_MIRROR |=>
    S_AXI_RVALID_OUT && S_AXI_RDATA_OUT[7:2] == 6'h00 &&
    S_AXI_RDATA_OUT[1:0] == $past(st_r.res))
    else $error("mirror read does not show the latched results");
  AST_RESULT_READ: assert property (
    ar_hs && S_AXI_ARADDR_IN == `ACMP_REG_CTRL0_C2 |=>
    S_AXI_RDATA_OUT[`ACMP_C0_RESULT] == $past(st_r.res[1]))
    else $error("control register does not show the latched result");
  AST_PORT_ANALOG: assert property (
    ar_hs && S_AXI_ARADDR_IN == `ACMP_REG_PORT |=>
    (S_AXI_RDATA_OUT[7:0] & $past(st_r.analog_select)) == 8'h00)
    else $error("analog pin read back as one");
  AST_FLAG_STICKY: assert property (
    st_r.flag[0] && clr_ev[0] == 1'b0 |=> st_r.flag[0])
    else $error("flag cleared without a software write");
  AST_SET_WINS: assert property (
    set_ev[1] && clr_ev[1] |=> st_r.flag[1])
    else $error("clear beat a simultaneous edge");
  AST_RISE_SETS: assert property (
    st_r.res[0] && !st_r.prev[0] && icyc && st_r.rise_en[0] |=> CMP_IRQ_FLAG_OUT[0])
    else $error("enabled rising edge did not set the flag");
  AST_FALL_SETS: assert property (
    !st_r.res[0] && st_r.prev[0] && icyc && st_r.fall_en[0] |=> CMP_IRQ_FLAG_OUT[0])
    else $error("enabled falling edge did not set the flag");
  AST_EDGE_PULSE: assert property (
    rise[0] || fall[0] |=> !rise[0] && !fall[0])
    else $error("edge pulse longer than one cycle");
  AST_LATCH_TIMING: assert property (
    !icyc |=> $stable(st_r.res))
    else $error("result changed outside the instruction cycle");
  AST_DISABLED_POLARITY: assert property (
    !st_r.en[1] && icyc ##1 !st_r.en[1] |-> st_r.res[1] == $past(st_r.inv[1]))
    else $error("disabled output is not the polarity bit");
  AST_SYNC_HOLD: assert property (
    st_r.sync[0] && !t1_fall |=> $stable(CMP_PIN_OUT[0]))
    else $error("synced pin output moved without a timer falling edge");
  AST_ASYNC_FOLLOW: assert property (
    !st_r.sync[1] |=> CMP_PIN_OUT[1] == $past(gated[1]))
    else $error("unsynced pin output does not follow the comparator");
  AST_GATE_FOLLOW: assert property (
    !st_r.sync[0] |=> TMR1_GATE_OUT[0] == $past(gated[0]))
    else $error("timer gate source does not follow the comparator");
  AST_SHUTDOWN_NOW: assert property (
    st_r.pin[0] && st_r.ase[0] |-> SHUTDOWN_REQ_OUT[0])
    else $error("active output with shutdown enabled gave no request");
  AST_HYS_FOLLOW: assert property (
    st_r.en[0] |-> CMP_HYSTERESIS_EN_OUT[0] == st_r.hys[0])
    else $error("hysteresis request differs from its control bit");
  AST_WRITE_RESP: assert property (
    wr_do |=> S_AXI_BVALID_OUT &&
    ($past(st_r.awaddr) != `ACMP_REG_CTRL0_C1 || !$past(st_r.wlane) ||
     CMP_ENABLE_OUT[0] == $past(st_r.wbyte[`ACMP_C0_ENABLE])))
    else $error("write not answered or enable bit not stored");

  COV_RISE_FLAG: cover property (set_ev[0] ##1 st_r.flag[0]);
  COV_SET_CLEAR: cover property (set_ev[1] && clr_ev[1]);
  COV_SYNC_UPDATE: cover property (st_r.sync[0] && t1_fall);
  COV_SHUTDOWN: cover property (SHUTDOWN_REQ_OUT[0]);
  COV_FALL_FLAG: cover property (fall[0] && st_r.fall_en[0]);
endmodule

// ===== inc/acmp_defines.svh
// register offsets, field positions, reset values and timing counts of the comparator block
`ifndef ACMP_DEFINES_SVH
`define ACMP_DEFINES_SVH
`define ACMP_REG_CTRL0_C1   8'h00
`define ACMP_REG_CTRL1_C1   8'h04
`define ACMP_REG_CTRL0_C2   8'h08
`define ACMP_REG_CTRL1_C2   8'h0c
`define ACMP_REG_MIRROR     8'h10
`define ACMP_REG_IRQ_FLAG   8'h14
`define ACMP_REG_IRQ_EN     8'h18
`define ACMP_REG_SHUTDOWN   8'h1c
`define ACMP_REG_ANALOG_SELECT      8'h20
`define ACMP_REG_PORT       8'h24
`define ACMP_C0_ENABLE      7
`define ACMP_C0_RESULT      6
`define ACMP_C0_INVERT      4
`define ACMP_C0_SPEED       2
`define ACMP_C0_HYS         1
`define ACMP_C0_SYNC        0
`define ACMP_C1_RISE        7
`define ACMP_C1_FALL        6
`define ACMP_C1_POS_LSB     3
`define ACMP_C1_NEG_LSB     0
`define ACMP_CTRL0_RESET    8'h04
`define ACMP_INSTR_DIV      2'h3
`define ACMP_RESP_OKAY      2'b00
`define ACMP_RESP_SLVERR    2'b10
`endif

// ===== inc/acmp_pkg.sv
// types shared by the comparator control block
package acmp_pkg;
  typedef enum logic [2:0] {
    WR_COLLECT = 3'b001,
    WR_EXEC    = 3'b010,
    WR_RESP    = 3'b100
  } wr_state_t;

  typedef struct packed {
    logic [1:0]      en;
    logic [1:0]      inv;
    logic [1:0]      spd;
    logic [1:0]      hys;
    logic [1:0]      sync;
    logic [1:0]      rise_en;
    logic [1:0]      fall_en;
    logic [1:0][2:0] psel;
    logic [1:0][2:0] nsel;
    logic [1:0]      res;
    logic [1:0]      prev;
    logic [1:0]      pin;
    logic [1:0]      flag;
    logic [1:0]      irq_en;
    logic [1:0]      ase;
    logic [7:0]      analog_select;
    logic [1:0]      div;
    logic            t1_prev;
    logic            aw_have;
    logic            w_have;
    logic [7:0]      awaddr;
    logic [7:0]      wbyte;
    logic            wlane;
    wr_state_t       wst;
    logic            bvalid;
    logic [1:0]      bresp;
    logic            rvalid;
    logic [31:0]     rdata;
    logic [1:0]      rresp;
  } core_state_t;
endpackage

// ===== verif/acmp_far_model.sv
// far-side model: timer1 clock and gate counter, waveform generator, interrupt controller
module acmp_far_model (
  input  wire logic        clk_in,
  input  wire logic        rst_in,
  input  wire logic        t1_run_in,
  input  wire logic        gsel_in,
  input  wire logic [1:0]  gate_in,
  input  wire logic [1:0]  shutdown_in,
  input  wire logic [1:0]  irq_req_in,
  input  wire logic        periph_en_in,
  input  wire logic        global_en_in,
  output logic             t1_clk_out,
  output logic [15:0]      t1_count_out,
  output logic             cwg_running_out,
  output logic             cpu_irq_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] div_r;
  // timer clock stands still low between runs, so no stray falling edges
  always @(posedge clk_in or posedge rst_in) begin
    if (rst_in || !t1_run_in) begin
      div_r <= 2'h0;
      t1_clk_out <= 1'h0;
    end else if (div_r == 2'h2) begin
      div_r <= 2'h0;
      t1_clk_out <= !t1_clk_out;
    end else begin
      div_r <= div_r + 2'h1;
    end
  end
  always @(posedge t1_clk_out or posedge rst_in) begin
    if (rst_in) begin
      t1_count_out <= 16'h0000;
    end else if (gate_in[gsel_in]) begin
      t1_count_out <= t1_count_out + 16'h0001;
    end
  end
  assign cwg_running_out = !(|shutdown_in);
  assign cpu_irq_out = (|irq_req_in) && periph_en_in && global_en_in;
endmodule

// ===== verif/tb_top.sv
// self-checking bench: register sequences over the register bus
`include "acmp_defines.svh"
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'h0, rst = 1'h1;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00, pins = 8'h00;
  logic [31:0] wdata = 32'h0, rdata;
  logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
  logic awready, wready, bvalid, arready, rvalid, t1clk, t1run = 1'h0, cwg_run, cpu_irq;
  logic [1:0] bresp, rresp, raw = 2'h0, en, spd, hys, pin, gate, sdn, flag, req, rsp;
  logic [7:0] pconn, rd;
  logic [11:0] nconn;
  logic [15:0] t1cnt, cnt0;
  int bad_count = 0, checked = 0;
  always #20 clk = !clk;
  analog_comparator_digital_ctrl i_analog_comparator_digital_ctrl (
    .SYS_CLK_IN(clk), .RST_IN(rst), .S_AXI_AWADDR_IN(awaddr), .S_AXI_AWVALID_IN(awvalid),
    .S_AXI_AWREADY_OUT(awready), .S_AXI_WDATA_IN(wdata), .S_AXI_WSTRB_IN(4'h1),
    .S_AXI_WVALID_IN(wvalid), .S_AXI_WREADY_OUT(wready), .S_AXI_BRESP_OUT(bresp),
    .S_AXI_BVALID_OUT(bvalid), .S_AXI_BREADY_IN(bready), .S_AXI_ARADDR_IN(araddr),
    .S_AXI_ARVALID_IN(arvalid), .S_AXI_ARREADY_OUT(arready), .S_AXI_RDATA_OUT(rdata),
    .S_AXI_RRESP_OUT(rresp), .S_AXI_RVALID_OUT(rvalid), .S_AXI_RREADY_IN(rready),
    .CMP_RAW_IN(raw), .T1_CLK_IN(t1clk), .PORT_PIN_IN(pins), .CMP_ENABLE_OUT(en),
    .CMP_SPEED_OUT(spd), .CMP_HYSTERESIS_EN_OUT(hys), .POS_CONNECT_OUT(pconn),
    .NEG_CONNECT_OUT(nconn), .CMP_PIN_OUT(pin), .TMR1_GATE_OUT(gate),
    .SHUTDOWN_REQ_OUT(sdn), .CMP_IRQ_FLAG_OUT(flag), .CMP_IRQ_REQ_OUT(req));
  acmp_far_model i_acmp_far_model (
    .clk_in(clk), .rst_in(rst), .t1_run_in(t1run), .gsel_in(1'h0), .gate_in(gate),
    .shutdown_in(sdn), .irq_req_in(req), .periph_en_in(1'h1), .global_en_in(1'h1),
    .t1_clk_out(t1clk), .t1_count_out(t1cnt), .cwg_running_out(cwg_run),
    .cpu_irq_out(cpu_irq));
  task automatic complete_run();
    $display("checked %0d bad_count %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      bad_count++;
      $display("Error %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic hang();
    bad_count++;
    $display("Error bus wait expected answer seen none");
    complete_run();
  endtask
  // master holds each channel until its own ready, bready until bvalid
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    int n;
    @(posedge clk);
    awaddr <= a;
    wdata <= 32'(d);
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    for (n = 0; n < 50; n++) begin
      @(posedge clk);
      if (awvalid && awready) awvalid <= 1'h0;
      if (wvalid && wready) wvalid <= 1'h0;
      if (bvalid) break;
    end
    rsp = bresp;
    bready <= 1'h0;
    if (n == 50) hang();
  endtask
  task automatic rdr(input logic [7:0] a);
    int n;
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'h1;
    rready <= 1'h1;
    for (n = 0; n < 50; n++) begin
      @(posedge clk);
      if (arvalid && arready) arvalid <= 1'h0;
      if (rvalid) break;
    end
    rd = rdata[7:0];
    rsp = rresp;
    chk("rdata upper", 32'(rdata[31:8]), 32'h0);
    rready <= 1'h0;
    if (n == 50) hang();
  endtask
  // latch, edge and flag take up to two instruction cycles after the synchroniser
  task automatic settle();
    repeat (16) @(posedge clk);
  endtask
  task automatic set_raw(input logic [1:0] v);
    @(posedge clk);
    raw <= v;
    settle();
  endtask
  initial begin
    logic [7:0] a0, a1;
    logic [3:0] ep;
    logic [5:0] en6;
    repeat (10) @(posedge clk);
    rst <= 1'h0;
    chk("speed out", 32'(spd), 32'h3);
    rdr(`ACMP_REG_CTRL0_C1);
    chk("ctrl0 reset", 32'(rd), 32'(`ACMP_CTRL0_RESET));
    rdr(`ACMP_REG_CTRL1_C2);
    chk("ctrl1 reset", 32'(rd), 32'h0);
    rdr(8'h30);
    chk("unmapped rresp", 32'(rsp), 32'(`ACMP_RESP_SLVERR));
    wr(8'h30, 8'hff);
    chk("unmapped bresp", 32'(rsp), 32'(`ACMP_RESP_SLVERR));
    wr(`ACMP_REG_MIRROR, 8'hff);
    rdr(`ACMP_REG_MIRROR);
    chk("mirror read only", 32'(rd), 32'h0);
    for (int i = 0; i < 2; i++) begin
      a0 = 8'(i * 8);
      a1 = 8'(i * 8 + 4);
      wr(a0, 8'h86);
      chk("enable out", 32'(en[i]), 32'h1);
      chk("hys out", 32'(hys[i]), 32'h1);
      set_raw(2'(1 << i));
      rdr(a0);
      chk("result", 32'(rd[`ACMP_C0_RESULT]), 32'h1);
      rdr(`ACMP_REG_MIRROR);
      chk("mirror", 32'(rd), 32'(1 << i));
      chk("pin out", 32'(pin[i]), 32'h1);
      chk("gate out", 32'(gate[i]), 32'h1);
      wr(a0, 8'h94);
      settle();
      rdr(a0);
      chk("inverted", 32'(rd[`ACMP_C0_RESULT]), 32'h0);
      chk("hys off", 32'(hys[i]), 32'h0);
      for (int k = 0; k < 8; k++) begin
        wr(a1, {2'h0, 3'(k), 3'(k)});
        ep = (k == 0) ? 4'h1 : (k == 5) ? 4'h2 : (k == 6) ? 4'h4 : (k == 7) ? 4'h8 : 4'h0;
        en6 = (k < 4) ? 6'(1 << k) : (k == 6) ? 6'h10 : (k == 7) ? 6'h20 : 6'h00;
        chk("pos route", 32'(pconn[4*i+:4]), 32'(ep));
        chk("neg route", 32'(nconn[6*i+:6]), 32'(en6));
      end
      wr(a0, 8'h04);
      chk("disabled pos", 32'(pconn[4*i+:4]), 32'h0);
      chk("disabled neg", 32'(nconn[6*i+:6]), 32'h0);
      chk("disabled en", 32'(en[i]), 32'h0);
      set_raw(2'h0);
    end
    wr(`ACMP_REG_CTRL0_C1, 8'h84);
    wr(`ACMP_REG_CTRL1_C1, 8'h80);
    wr(`ACMP_REG_IRQ_EN, 8'h01);
    wr(`ACMP_REG_IRQ_FLAG, 8'h00);
    set_raw(2'h1);
    chk("rise flag", 32'(flag), 32'h1);
    chk("irq req", 32'(req), 32'h1);
    chk("cpu irq", 32'(cpu_irq), 32'h1);
    set_raw(2'h0);
    settle();
    chk("flag sticky", 32'(flag), 32'h1);
    // software clears the flag by writing zero
    wr(`ACMP_REG_IRQ_FLAG, 8'h00);
    rdr(`ACMP_REG_IRQ_FLAG);
    chk("flag cleared", 32'(rd), 32'h0);
    wr(`ACMP_REG_CTRL1_C1, 8'h40);
    set_raw(2'h1);
    chk("rise masked", 32'(flag), 32'h0);
    set_raw(2'h0);
    chk("fall flag", 32'(flag), 32'h1);
    wr(`ACMP_REG_IRQ_FLAG, 8'h00);
    wr(`ACMP_REG_CTRL0_C1, 8'h04);
    wr(`ACMP_REG_CTRL1_C1, 8'h80);
    wr(`ACMP_REG_IRQ_FLAG, 8'h00);
    wr(`ACMP_REG_CTRL0_C1, 8'h14);
    settle();
    chk("invert edge", 32'(flag), 32'h1);
    wr(`ACMP_REG_CTRL0_C1, 8'h84);
    set_raw(2'h1);
    wr(`ACMP_REG_SHUTDOWN, 8'h01);
    chk("shutdown req", 32'(sdn), 32'h1);
    chk("cwg stopped", 32'(cwg_run), 32'h0);
    wr(`ACMP_REG_SHUTDOWN, 8'h00);
    chk("shutdown off", 32'(sdn), 32'h0);
    set_raw(2'h0);
    // sync the gate source before timing with it
    wr(`ACMP_REG_CTRL0_C1, 8'h85);
    set_raw(2'h1);
    chk("sync hold pin", 32'(pin[0]), 32'h0);
    rdr(`ACMP_REG_CTRL0_C1);
    chk("latched result", 32'(rd[`ACMP_C0_RESULT]), 32'h1);
    t1run <= 1'h1;
    settle();
    t1run <= 1'h0;
    settle();
    chk("sync pin", 32'(pin[0]), 32'h1);
    cnt0 = t1cnt;
    t1run <= 1'h1;
    settle();
    t1run <= 1'h0;
    chk("timer gated", 32'(t1cnt > cnt0), 32'h1);
    @(posedge clk);
    pins <= 8'hff;
    // analog pins read back as zero
    wr(`ACMP_REG_ANALOG_SELECT, 8'h0f);
    settle();
    rdr(`ACMP_REG_PORT);
    chk("port data", 32'(rd), 32'hf0);
    // second comparator toggles each instruction cycle while software clears;
    // a five-cycle write period walks the clear across every phase of the divider
    wr(`ACMP_REG_CTRL0_C2, 8'h84);
    wr(`ACMP_REG_CTRL1_C2, 8'hc0);
    fork
      repeat (10) begin
        @(posedge clk);
        raw <= raw ^ 2'h2;
        repeat (3) @(posedge clk);
      end
      repeat (6) wr(`ACMP_REG_IRQ_FLAG, 8'h00);
    join
    chk("set beats clear", 32'(flag[1]), 32'h1);
    complete_run();
  end
  initial begin
    repeat (90000) @(posedge clk);
    bad_count++;
    $display("Error run time expected end seen limit");
    complete_run();
  end
endmodule
